// >>> verilog/oag_pkg.sv
// constants and types shared by the operand address generator
`default_nettype none
package oag_pkg;
  localparam int NUM_WREGS = 16;
  localparam int ADDR_W = 16;
  localparam int NEAR_W = 13;
  localparam logic [15:0] NEAR_TOP = 16'h2000;
  localparam logic [15:0] MAPPED_TOP = 16'h0020;
  localparam int MAP_REG_LSB = 1;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] STEP_DWORD = 16'h0004;
  localparam logic [15:0] MASK_BYTE = 16'hffff;
  localparam logic [15:0] MASK_WORD = 16'hfffe;
  localparam logic [15:0] MASK_DWORD = 16'hfffc;
  localparam int OP_SRC_A = 0;
  localparam int OP_SRC_B = 1;
  localparam int OP_DST = 2;
  localparam int NUM_OPS = 3;

  typedef enum logic [2:0] {
    OAG_M_REG = 3'b000,
    OAG_M_LIT = 3'b001,
    OAG_M_IND = 3'b010,
    OAG_M_PREINC = 3'b011,
    OAG_M_PREDEC = 3'b100,
    OAG_M_POSTINC = 3'b101,
    OAG_M_POSTDEC = 3'b110,
    OAG_M_OFFSET = 3'b111
  } oag_mode_e;

  typedef enum logic [1:0] {
    OAG_SZ_BYTE = 2'b00,
    OAG_SZ_WORD = 2'b01,
    OAG_SZ_DWORD = 2'b10
  } oag_size_e;

  typedef logic [NUM_WREGS-1:0][ADDR_W-1:0] oag_wfile_t;

  typedef struct packed {
    oag_mode_e mode;
    logic [3:0] work_pointer_reg;
    logic [3:0] offset_work_reg;
    logic [NEAR_W-1:0] near_addr;
  } oag_opnd_s;

  typedef struct packed {
    logic valid;
    oag_size_e size;
    logic dst_used;
    oag_opnd_s [NUM_OPS-1:0] opnd;
  } oag_instr_s;

  typedef struct packed {
    logic is_mem;
    logic [ADDR_W-1:0] addr;
    logic [3:0] work_pointer_reg;
    logic ptr_we;
    logic [ADDR_W-1:0] ptr_val;
  } oag_eff_s;
endpackage : oag_pkg
`default_nettype wire

// >>> verilog/oag_addr_gen.sv
// operand address generation and read-after-write stall control
`default_nettype none
module oag_addr_gen (
  input wire logic ref_clk,
  input wire logic rst,
  input wire oag_pkg::oag_instr_s in_instr,
  output logic in_ready,
  input wire oag_pkg::oag_wfile_t work_regs,
  output logic ex_valid,
  output logic ex_nop,
  output oag_pkg::oag_size_e ex_size,
  output logic ex_dst_used,
  output oag_pkg::oag_eff_s [oag_pkg::NUM_OPS-1:0] ex_eff
);

  function automatic logic is_ind(input oag_pkg::oag_mode_e m);
    is_ind = (m != oag_pkg::OAG_M_REG) && (m != oag_pkg::OAG_M_LIT);
  endfunction

  function automatic logic [15:0] step_of(input oag_pkg::oag_size_e sz);
    case (sz)
      oag_pkg::OAG_SZ_BYTE: step_of = oag_pkg::STEP_BYTE;
      oag_pkg::OAG_SZ_WORD: step_of = oag_pkg::STEP_WORD;
      default: step_of = oag_pkg::STEP_DWORD;
    endcase
  endfunction

  function automatic logic [15:0] mask_of(input oag_pkg::oag_size_e sz);
    case (sz)
      oag_pkg::OAG_SZ_BYTE: mask_of = oag_pkg::MASK_BYTE;
      oag_pkg::OAG_SZ_WORD: mask_of = oag_pkg::MASK_WORD;
      default: mask_of = oag_pkg::MASK_DWORD;
    endcase
  endfunction

  // a pointer is "used" by the address path whether as base or offset
  function automatic logic uses_reg(input oag_pkg::oag_opnd_s o, input logic [15:0] wmask);
    uses_reg = is_ind(o.mode) && (wmask[o.work_pointer_reg] ||
      ((o.mode == oag_pkg::OAG_M_OFFSET) && wmask[o.offset_work_reg]));
  endfunction

  function automatic oag_pkg::oag_eff_s calc_eff(input oag_pkg::oag_opnd_s o,
                                                 input oag_pkg::oag_size_e sz,
                                                 input oag_pkg::oag_wfile_t w);
    logic [15:0] p;
    logic [15:0] s;
    logic [15:0] a;
    oag_pkg::oag_eff_s e;
    p = w[o.work_pointer_reg];
    s = step_of(sz);
    a = p;
    e = '0;
    e.work_pointer_reg = o.work_pointer_reg;
    e.is_mem = (o.mode != oag_pkg::OAG_M_REG);
    case (o.mode)
      oag_pkg::OAG_M_REG: a = '0;
      // literal field is only 13 bits wide, so upper memory is unreachable here
      oag_pkg::OAG_M_LIT: a = 16'(o.near_addr);
      oag_pkg::OAG_M_IND: a = p;
      oag_pkg::OAG_M_PREINC: begin
        a = p + s;
        e.ptr_we = 1'b1;
        e.ptr_val = p + s;
      end
      oag_pkg::OAG_M_PREDEC: begin
        a = p - s;
        e.ptr_we = 1'b1;
        e.ptr_val = p - s;
      end
      oag_pkg::OAG_M_POSTINC: begin
        e.ptr_we = 1'b1;
        e.ptr_val = p + s;
      end
      oag_pkg::OAG_M_POSTDEC: begin
        e.ptr_we = 1'b1;
        e.ptr_val = p - s;
      end
      oag_pkg::OAG_M_OFFSET: a = p + w[o.offset_work_reg];
      default: a = p;
    endcase
    e.addr = a & mask_of(sz);
    calc_eff = e;
  endfunction

  oag_pkg::oag_instr_s ex_ins;
  logic [oag_pkg::NUM_OPS-1:0][15:0] ex_old;
  logic [15:0] ex_wr_mask;
  logic [oag_pkg::NUM_OPS-1:0] op_hit;
  logic hazard;
  logic accept;

  // registers the previous instruction will have changed by writeback
  always_comb begin
    ex_wr_mask = '0;
    if (ex_valid) begin
      for (int k = 0; k < oag_pkg::NUM_OPS; k++) begin
        if (ex_eff[k].ptr_we) begin
          ex_wr_mask[ex_eff[k].work_pointer_reg] = 1'b1;
        end
      end
      if (ex_dst_used && !ex_eff[oag_pkg::OP_DST].is_mem) begin
        ex_wr_mask[ex_eff[oag_pkg::OP_DST].work_pointer_reg] = 1'b1;
      end
      // only a memory write landing in the mapped window can alias a register;
      // other indirect writes need no interlock
      if (ex_dst_used && is_ind(ex_ins.opnd[oag_pkg::OP_DST].mode) &&
          (ex_eff[oag_pkg::OP_DST].addr < oag_pkg::MAPPED_TOP)) begin
        ex_wr_mask[ex_eff[oag_pkg::OP_DST].addr[oag_pkg::MAP_REG_LSB +: 4]] = 1'b1;
      end
    end
  end

  // direct operands never look at the mask, so direct reads never stall
  genvar g;
  generate
    for (g = 0; g < oag_pkg::NUM_OPS; g++) begin : g_hit
      if (g == oag_pkg::OP_DST) begin : g_d
        assign op_hit[g] = in_instr.dst_used && uses_reg(in_instr.opnd[g], ex_wr_mask);
      end else begin : g_s
        assign op_hit[g] = uses_reg(in_instr.opnd[g], ex_wr_mask);
      end
    end
  endgenerate

  // the bubble clears ex_valid, so a stall can never last past one cycle
  assign hazard = in_instr.valid && (|op_hit);
  assign in_ready = !hazard;
  assign accept = in_instr.valid && in_ready;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ex_valid <= 1'b0;
      ex_nop <= 1'b0;
    end else begin
      ex_valid <= accept;
      ex_nop <= hazard;
    end
  end

  // operand fields hold during a stall; only ex_valid drops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ex_ins <= '0;
      ex_size <= oag_pkg::OAG_SZ_BYTE;
      ex_dst_used <= 1'b0;
    end else if (accept) begin
      ex_ins <= in_instr;
      ex_size <= in_instr.size;
      ex_dst_used <= in_instr.dst_used;
    end
  end

  generate
    for (g = 0; g < oag_pkg::NUM_OPS; g++) begin : g_eff
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          ex_eff[g] <= '0;
          ex_old[g] <= '0;
        end else if (accept) begin
          ex_eff[g] <= calc_eff(in_instr.opnd[g], in_instr.size, work_regs);
          ex_old[g] <= work_regs[in_instr.opnd[g].work_pointer_reg];
        end
      end
    end
  endgenerate

  chk_stall_once: assert property (@(posedge ref_clk) disable iff (rst)
    hazard |=> !hazard)
    else $error("stall lasted more than one cycle");

  chk_stall_bubble: assert property (@(posedge ref_clk) disable iff (rst)
    hazard |=> (ex_nop && !ex_valid) ##1 !ex_nop)
    else $error("stall did not issue a single bubble");

  chk_byte_step: assert property (@(posedge ref_clk) disable iff (rst)
    ex_valid && ex_size == oag_pkg::OAG_SZ_BYTE &&
    ex_ins.opnd[oag_pkg::OP_SRC_A].mode == oag_pkg::OAG_M_POSTINC
    |-> ex_eff[oag_pkg::OP_SRC_A].ptr_we &&
        ex_eff[oag_pkg::OP_SRC_A].ptr_val == ex_old[oag_pkg::OP_SRC_A] + 16'h0001)
    else $error("byte post-increment step wrong");

  chk_word_step: assert property (@(posedge ref_clk) disable iff (rst)
    ex_valid && ex_size == oag_pkg::OAG_SZ_WORD &&
    ex_ins.opnd[oag_pkg::OP_SRC_A].mode == oag_pkg::OAG_M_PREDEC
    |-> ex_eff[oag_pkg::OP_SRC_A].ptr_val == ex_old[oag_pkg::OP_SRC_A] - 16'h0002 &&
        ex_eff[oag_pkg::OP_SRC_A].addr == (ex_eff[oag_pkg::OP_SRC_A].ptr_val & 16'hfffe))
    else $error("word pre-decrement step wrong");

  chk_offset_keep: assert property (@(posedge ref_clk) disable iff (rst)
    ex_valid && ex_ins.opnd[oag_pkg::OP_SRC_A].mode == oag_pkg::OAG_M_OFFSET
    |-> !ex_eff[oag_pkg::OP_SRC_A].ptr_we)
    else $error("offset mode modified its pointer");

  chk_lit_near: assert property (@(posedge ref_clk) disable iff (rst)
    ex_valid && ex_ins.opnd[oag_pkg::OP_SRC_A].mode == oag_pkg::OAG_M_LIT
    |-> ex_eff[oag_pkg::OP_SRC_A].is_mem && ex_eff[oag_pkg::OP_SRC_A].addr < oag_pkg::NEAR_TOP)
    else $error("literal address left the near region");

  chk_ptr_raw: assert property (@(posedge ref_clk) disable iff (rst)
    ex_valid && ex_eff[oag_pkg::OP_SRC_A].ptr_we && in_instr.valid &&
    is_ind(in_instr.opnd[oag_pkg::OP_SRC_A].mode) &&
    in_instr.opnd[oag_pkg::OP_SRC_A].work_pointer_reg == ex_eff[oag_pkg::OP_SRC_A].work_pointer_reg
    |-> !in_ready ##1 in_ready)
    else $error("pointer dependency not stalled exactly once");

  chk_mapped_raw: assert property (@(posedge ref_clk) disable iff (rst)
    ex_valid && ex_dst_used && is_ind(ex_ins.opnd[oag_pkg::OP_DST].mode) &&
    ex_eff[oag_pkg::OP_DST].addr < oag_pkg::MAPPED_TOP && in_instr.valid &&
    is_ind(in_instr.opnd[oag_pkg::OP_SRC_A].mode) &&
    in_instr.opnd[oag_pkg::OP_SRC_A].work_pointer_reg == ex_eff[oag_pkg::OP_DST].addr[4:1]
    |-> !in_ready)
    else $error("mapped register write not stalled");

  chk_direct_free: assert property (@(posedge ref_clk) disable iff (rst)
    in_instr.valid && !is_ind(in_instr.opnd[oag_pkg::OP_SRC_A].mode) &&
    !is_ind(in_instr.opnd[oag_pkg::OP_SRC_B].mode) &&
    !(in_instr.dst_used && is_ind(in_instr.opnd[oag_pkg::OP_DST].mode))
    |-> in_ready ##1 ex_valid)
    else $error("direct operands stalled");

  chk_word_align: assert property (@(posedge ref_clk) disable iff (rst)
    ex_valid && ex_size == oag_pkg::OAG_SZ_WORD && ex_eff[oag_pkg::OP_SRC_B].is_mem
    |-> !ex_eff[oag_pkg::OP_SRC_B].addr[0])
    else $error("word operand misaligned");

  chk_reset_quiet: assert property (@(posedge ref_clk)
    rst |=> !ex_valid && !ex_nop)
    else $error("outputs active after reset");

  chk_ready_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !ex_valid |-> in_ready)
    else $error("stall raised with no producer in flight");

  chk_issue_next: assert property (@(posedge ref_clk) disable iff (rst)
    in_instr.valid && in_ready |=> ex_valid && !ex_nop)
    else $error("accepted instruction did not issue next cycle");

  chk_no_issue: assert property (@(posedge ref_clk) disable iff (rst)
    !(in_instr.valid && in_ready) |=> !ex_valid)
    else $error("issue without an accepted instruction");

  chk_held_regs: assert property (@(posedge ref_clk) disable iff (rst)
    !(in_instr.valid && in_ready) |=> $stable(ex_eff) && $stable(ex_size))
    else $error("pipeline registers moved while nothing was taken");

  chk_dst_raw: assert property (@(posedge ref_clk) disable iff (rst)
    ex_valid && ex_dst_used && !ex_eff[oag_pkg::OP_DST].is_mem && in_instr.valid &&
    is_ind(in_instr.opnd[oag_pkg::OP_SRC_A].mode) &&
    in_instr.opnd[oag_pkg::OP_SRC_A].work_pointer_reg == ex_eff[oag_pkg::OP_DST].work_pointer_reg
    |-> !in_ready)
    else $error("direct register write not interlocked");

  chk_offset_raw: assert property (@(posedge ref_clk) disable iff (rst)
    ex_valid && ex_dst_used && !ex_eff[oag_pkg::OP_DST].is_mem && in_instr.valid &&
    in_instr.opnd[oag_pkg::OP_SRC_A].mode == oag_pkg::OAG_M_OFFSET &&
    in_instr.opnd[oag_pkg::OP_SRC_A].offset_work_reg == ex_eff[oag_pkg::OP_DST].work_pointer_reg
    |-> !in_ready)
    else $error("offset register dependency not interlocked");

  // an unmapped plain indirect write leaves every working register alone
  chk_unmapped_free: assert property (@(posedge ref_clk) disable iff (rst)
    ex_valid && ex_dst_used && ex_ins.opnd[oag_pkg::OP_DST].mode == oag_pkg::OAG_M_IND &&
    ex_eff[oag_pkg::OP_DST].addr >= oag_pkg::MAPPED_TOP &&
    !ex_eff[oag_pkg::OP_SRC_A].ptr_we && !ex_eff[oag_pkg::OP_SRC_B].ptr_we &&
    in_instr.valid && is_ind(in_instr.opnd[oag_pkg::OP_SRC_A].mode) &&
    in_instr.opnd[oag_pkg::OP_SRC_A].work_pointer_reg == ex_eff[oag_pkg::OP_DST].work_pointer_reg
    |-> in_ready)
    else $error("unmapped indirect write stalled");

  chk_reg_direct: assert property (@(posedge ref_clk) disable iff (rst)
    ex_valid && ex_ins.opnd[oag_pkg::OP_DST].mode == oag_pkg::OAG_M_REG
    |-> !ex_eff[oag_pkg::OP_DST].is_mem && !ex_eff[oag_pkg::OP_DST].ptr_we)
    else $error("register-direct destination treated as memory");

  chk_lit_direct: assert property (@(posedge ref_clk) disable iff (rst)
    ex_valid && ex_ins.opnd[oag_pkg::OP_SRC_B].mode == oag_pkg::OAG_M_LIT
    |-> !ex_eff[oag_pkg::OP_SRC_B].ptr_we && ex_eff[oag_pkg::OP_SRC_B].addr ==
        (16'(ex_ins.opnd[oag_pkg::OP_SRC_B].near_addr) & mask_of(ex_size)))
    else $error("literal operand address wrong");

  // per-operand checks against the pointer value captured at issue, or the stepped ptr_val for pre-modified modes
  generate
    for (g = 0; g < oag_pkg::NUM_OPS; g++) begin : g_chk
      chk_post_addr: assert property (@(posedge ref_clk) disable iff (rst)
        ex_valid && ex_ins.opnd[g].mode inside {oag_pkg::OAG_M_POSTINC, oag_pkg::OAG_M_POSTDEC}
        |-> ex_eff[g].addr == (ex_old[g] & mask_of(ex_size)))
        else $error("post-modified operand did not use the old pointer");

      chk_pre_addr: assert property (@(posedge ref_clk) disable iff (rst)
        ex_valid && ex_ins.opnd[g].mode inside {oag_pkg::OAG_M_PREINC, oag_pkg::OAG_M_PREDEC}
        |-> ex_eff[g].ptr_we && ex_eff[g].addr == (ex_eff[g].ptr_val & mask_of(ex_size)))
        else $error("pre-modified operand did not use the stepped pointer");

      chk_plain_keep: assert property (@(posedge ref_clk) disable iff (rst)
        ex_valid && ex_ins.opnd[g].mode == oag_pkg::OAG_M_IND
        |-> !ex_eff[g].ptr_we && ex_eff[g].addr == (ex_old[g] & mask_of(ex_size)))
        else $error("plain indirect operand changed its pointer");

      chk_step_size: assert property (@(posedge ref_clk) disable iff (rst)
        ex_valid && ex_ins.opnd[g].mode == oag_pkg::OAG_M_POSTDEC
        |-> ex_eff[g].ptr_we && ex_eff[g].ptr_val == ex_old[g] - step_of(ex_size))
        else $error("post-decrement step does not match the size");

      chk_dword_step: assert property (@(posedge ref_clk) disable iff (rst)
        ex_valid && ex_size == oag_pkg::OAG_SZ_DWORD &&
        ex_ins.opnd[g].mode == oag_pkg::OAG_M_POSTINC
        |-> ex_eff[g].ptr_val == ex_old[g] + oag_pkg::STEP_DWORD)
        else $error("double-word step wrong");
    end
  endgenerate

endmodule // oag_addr_gen
`default_nettype wire

// >>> dv/oag_regfile_model.sv
// working register file and data write model behind the address generator
`default_nettype none
module oag_regfile_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire oag_pkg::oag_wfile_t init_regs,
  input wire logic ex_valid,
  input wire logic ex_dst_used,
  input wire oag_pkg::oag_eff_s [2:0] ex_eff,
  output var oag_pkg::oag_wfile_t work_regs
);
  timeunit 1ns;
  timeprecision 1ps;
  oag_pkg::oag_eff_s d;
  assign d = ex_eff[2];
  // result is old value plus 10h so a stale pointer read shows up
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      work_regs <= init_regs;
    end else if (ex_valid) begin
      for (int k = 0; k < 3; k++) begin
        if (ex_eff[k].ptr_we) work_regs[ex_eff[k].work_pointer_reg] <= ex_eff[k].ptr_val;
      end
      if (ex_dst_used && !d.is_mem) begin
        work_regs[d.work_pointer_reg] <= work_regs[d.work_pointer_reg] + 16'h0010;
      end else if (ex_dst_used && d.addr < 16'h0020) begin
        work_regs[d.addr[4:1]] <= work_regs[d.addr[4:1]] + 16'h0010;
      end
    end
  end
endmodule // oag_regfile_model
`default_nettype wire

// >>> dv/tb_oag_addr_gen.sv
// self-checking bench for the operand address generator
`default_nettype none
module tb_oag_addr_gen;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    oag_pkg::oag_size_e size;
    logic dst;
    logic [2:0] lit;
    oag_pkg::oag_eff_s [2:0] eff;
  } oag_exp_s;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic in_ready, ex_valid, ex_nop, ex_dst_used;
  logic [31:0] r;
  oag_pkg::oag_instr_s in_instr = '0;
  oag_pkg::oag_size_e ex_size;
  oag_pkg::oag_eff_s [2:0] ex_eff;
  oag_pkg::oag_wfile_t work_regs, init_regs, sh;
  oag_exp_s q[$];
  oag_exp_s m;
  int num_errors = 0, checked = 0, nops = 0, stalls = 0;
  initial forever #5 ref_clk = ~ref_clk;
  oag_addr_gen u_dut (.ref_clk(ref_clk), .rst(rst), .in_instr(in_instr), .in_ready(in_ready),
    .work_regs(work_regs), .ex_valid(ex_valid), .ex_nop(ex_nop), .ex_size(ex_size),
    .ex_dst_used(ex_dst_used), .ex_eff(ex_eff));
  oag_regfile_model u_regs (.ref_clk(ref_clk), .rst(rst), .init_regs(init_regs),
    .ex_valid(ex_valid), .ex_dst_used(ex_dst_used), .ex_eff(ex_eff), .work_regs(work_regs));
  task automatic conclude;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_eff(input oag_pkg::oag_eff_s g, input oag_pkg::oag_eff_s e,
      input logic lit);
    checked++;
    if (g.is_mem !== e.is_mem || (e.is_mem && g.addr !== e.addr) || g.ptr_we !== e.ptr_we
        || (e.ptr_we && g.ptr_val !== e.ptr_val)
        || (!lit && g.work_pointer_reg !== e.work_pointer_reg)) begin
      num_errors++;
      $display("Error at %0t: operand %h expected %h", $time, g, e);
    end
  endtask
  function automatic oag_pkg::oag_instr_s mk(input logic [2:0] m0, input logic [3:0] r0,
      input logic [2:0] m2, input logic [3:0] r2, input logic [1:0] sz);
    oag_pkg::oag_instr_s i;
    i = '0;
    i.valid = 1'b1;
    i.size = oag_pkg::oag_size_e'(sz);
    i.dst_used = 1'b1;
    i.opnd[0].mode = oag_pkg::oag_mode_e'(m0);
    i.opnd[0].work_pointer_reg = r0;
    i.opnd[0].offset_work_reg = 4'd10;
    i.opnd[1].mode = oag_pkg::OAG_M_LIT;
    i.opnd[1].near_addr = 13'($urandom());
    i.opnd[2].mode = oag_pkg::oag_mode_e'(m2);
    i.opnd[2].work_pointer_reg = r2;
    return i;
  endfunction
  // predicts from the shadow file, then retires into it in the model's write order
  task automatic issue(input oag_pkg::oag_instr_s ins, input int stall);
    oag_exp_s e;
    oag_pkg::oag_opnd_s o;
    logic [15:0] st, p;
    int n;
    st = 16'h0001 << ins.size;
    e = '0;
    e.size = ins.size;
    e.dst = ins.dst_used;
    for (int k = 0; k < 3; k++) begin
      o = ins.opnd[k];
      p = sh[o.work_pointer_reg];
      e.lit[k] = o.mode == 3'h1;
      e.eff[k].is_mem = o.mode != 3'h0;
      e.eff[k].work_pointer_reg = o.work_pointer_reg;
      e.eff[k].ptr_we = o.mode inside {[3'h3:3'h6]};
      e.eff[k].ptr_val = o.mode[0] ? p + st : p - st;
      e.eff[k].addr = o.mode == 3'h3 || o.mode == 3'h4 ? e.eff[k].ptr_val : p;
      if (o.mode == 3'h1) e.eff[k].addr = 16'(o.near_addr);
      if (o.mode == 3'h7) e.eff[k].addr = p + sh[o.offset_work_reg];
      // the operand size keeps the address aligned
      e.eff[k].addr &= ~(st - 16'h0001);
    end
    for (int k = 0; k < 3; k++) begin
      if (e.eff[k].ptr_we) sh[e.eff[k].work_pointer_reg] = e.eff[k].ptr_val;
    end
    if (!e.eff[2].is_mem) sh[e.eff[2].work_pointer_reg] += 16'h0010;
    else if (e.eff[2].addr < 16'h0020) sh[e.eff[2].addr[4:1]] += 16'h0010;
    in_instr <= ins;
    n = 0;
    @(negedge ref_clk);
    while (in_ready !== 1'b1) begin
      n++;
      if (n > 3) begin
        num_errors++;
        conclude();
      end
      @(negedge ref_clk);
    end
    check_val(16'(n), 16'(stall));
    stalls += stall;
    q.push_back(e);
    @(posedge ref_clk);
  endtask
  task automatic pair(input logic [2:0] pm, input logic [3:0] pr, input logic [2:0] cm,
      input logic [3:0] cr, input int stall);
    issue(mk(3'h0, 4'd12, pm, pr, 2'd1), 0);
    issue(mk(cm, cr, 3'h0, 4'd15, 2'd1), stall);
  endtask
  always @(negedge ref_clk) begin
    if (ex_nop === 1'b1) nops++;
    if (ex_valid === 1'b1 && q.size() == 0) check_val(16'h0001, 16'h0000);
    else if (ex_valid === 1'b1) begin
      m = q.pop_front();
      check_val(16'(ex_size), 16'(m.size));
      check_val(16'(ex_dst_used), 16'(m.dst));
      for (int k = 0; k < 3; k++) begin
        check_eff(ex_eff[k], m.eff[k], m.lit[k]);
      end
    end
  end
  initial begin
    void'($urandom(32'hfec2));
    for (int i = 0; i < 16; i++) begin
      r = $urandom();
      init_regs[i] = r[15:0] & 16'h7ffc | 16'h0100;
    end
    // pointer 3 aims at the mapped copy of register 2
    init_regs[3] = 16'h0004;
    sh = init_regs;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    for (int s = 2; s >= 0; s--) begin
      for (int k = 0; k < 8; k++) begin
        issue(mk(3'(k), 4'(k + 2), 3'h0, 4'd15, 2'(s)), 0);
      end
    end
    pair(3'h0, 4'd2, 3'h2, 4'd2, 1);
    pair(3'h0, 4'd2, 3'h3, 4'd2, 1);
    pair(3'h2, 4'd3, 3'h2, 4'd2, 1);
    pair(3'h5, 4'd11, 3'h2, 4'd11, 1);
    pair(3'h2, 4'd11, 3'h6, 4'd11, 0);
    pair(3'h0, 4'd2, 3'h0, 4'd2, 0);
    pair(3'h4, 4'd11, 3'h0, 4'd11, 0);
    pair(3'h0, 4'd10, 3'h7, 4'd11, 1);
    issue(mk(3'h5, 4'd9, 3'h0, 4'd15, 2'd1), 0);
    issue(mk(3'h2, 4'd9, 3'h0, 4'd15, 2'd1), 1);
    in_instr <= '0;
    repeat (4) @(posedge ref_clk);
    check_val(16'(nops), 16'(stalls));
    check_val(16'(q.size()), 16'h0000);
    conclude();
  end
endmodule // tb_oag_addr_gen
`default_nettype wire
